// file: txd_pkg.sv
// Package with opcode encodings and decode constants for the trap/xor decoder
package txd_pkg;
  localparam int XLEN = 64;
  localparam int IMM_W = 16;
  // Instruction field positions
  localparam int OP_HI = 31;
  localparam int OP_LO = 26;
  localparam int ROW_HI = 31;
  localparam int ROW_LO = 29;
  localparam int COL_HI = 28;
  localparam int COL_LO = 26;
  localparam int SRC1_HI = 25;
  localparam int SRC1_LO = 21;
  localparam int SRC2_HI = 20;
  localparam int SRC2_LO = 16;
  localparam int RD_HI = 15;
  localparam int RD_LO = 11;
  localparam int FN_HI = 5;
  localparam int FN_LO = 0;
  localparam int CODE_HI = 15;
  localparam int CODE_LO = 6;
  // Primary opcodes
  localparam logic [5:0] OP_FUNCTION_GROUP = 6'h00;
  localparam logic [5:0] OP_BRANCH_TRAP_IMM = 6'h01;
  localparam logic [5:0] OP_XOR_IMM = 6'h0e;
  localparam logic [5:0] OP_SYSTEM_COPROC = 6'h10;
  localparam logic [5:0] OP_JUMP_LINK_EXCHANGE = 6'h1d;
  // Function codes
  localparam logic [5:0] FN_XOR = 6'h26;
  localparam logic [5:0] FN_TRAP_LT_U = 6'h33;
  localparam logic [5:0] FN_TRAP_NEQ = 6'h36;
  // Branch/trap immediate second-register codes
  localparam logic [4:0] SEL_TRAP_LT_IMM_U = 5'h0b;
  localparam logic [4:0] SEL_TRAP_NEQ_IMM = 5'h0e;
  // Coprocessor-0 function codes
  localparam logic [5:0] CP0_STANDBY = 6'h21;
  localparam logic [5:0] CP0_SUSPEND = 6'h22;
  localparam logic [5:0] CP0_POWER_DOWN_DEEP = 6'h23;

  typedef enum logic [3:0] {
    TXD_CLS_VALID,
    TXD_CLS_RESERVED,
    TXD_CLS_GAMMA,
    TXD_CLS_PHI,
    TXD_CLS_XI,
    TXD_CLS_DWORD,
    TXD_CLS_COPROC,
    TXD_CLS_EXCHANGE
  } txd_class_t;

  typedef enum logic [2:0] {
    TXD_PD_NONE,
    TXD_PD_STANDBY,
    TXD_PD_SUSPEND,
    TXD_PD_DEEP
  } txd_pd_t;
endpackage : txd_pkg

// file: txd_map_if.sv
// Interface carrying the decode-map lookup between the core and its map table
`timescale 1ns/10ps
interface txd_map_if;
  import txd_pkg::*;
  logic [31:0] instr;
  txd_class_t cls;
  txd_pd_t pd;
  modport core (output instr, input cls, pd);
  modport map (input instr, output cls, pd);
endinterface : txd_map_if

// file: txd_opmap.sv
// Combinational opcode map classifier for primary, function and cp0 groups
`timescale 1ns/10ps
module txd_opmap
  import txd_pkg::*;
(
  txd_map_if.map m
);
  logic [2:0] row;
  logic [2:0] col;
  logic [5:0] fn;
  logic [4:0] src1_sel;
  logic [4:0] src2_sel;
  assign row = m.instr[ROW_HI:ROW_LO];
  assign col = m.instr[COL_HI:COL_LO];
  assign fn = m.instr[FN_HI:FN_LO];
  assign src1_sel = m.instr[SRC1_HI:SRC1_LO];
  assign src2_sel = m.instr[SRC2_HI:SRC2_LO];

  always_comb
  begin
    m.cls = TXD_CLS_VALID;
    m.pd = TXD_PD_NONE;
    unique case ({row, col})
      OP_FUNCTION_GROUP:
      begin
        unique case (fn)
          6'h01, 6'h05, 6'h0a, 6'h0b, 6'h0e, 6'h15, 6'h35, 6'h37, 6'h39, 6'h3d:
            m.cls = TXD_CLS_RESERVED;
          6'h14, 6'h16, 6'h17, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h2c, 6'h2d, 6'h2e,
          6'h2f, 6'h38, 6'h3a, 6'h3b, 6'h3c, 6'h3e, 6'h3f:
            m.cls = TXD_CLS_DWORD;
          default: m.cls = TXD_CLS_VALID;
        endcase
      end
      OP_BRANCH_TRAP_IMM:
      begin
        unique case (src2_sel)
          5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e,
          5'h10, 5'h11, 5'h12, 5'h13:
            m.cls = TXD_CLS_VALID;
          default: m.cls = TXD_CLS_RESERVED;
        endcase
      end
      OP_SYSTEM_COPROC:
      begin
        if (src1_sel[4])
        begin
          unique case (fn)
            6'h01, 6'h02, 6'h06, 6'h08, 6'h18: m.cls = TXD_CLS_VALID;
            6'h10: m.cls = TXD_CLS_XI;
            CP0_STANDBY: m.pd = TXD_PD_STANDBY;
            CP0_SUSPEND: m.pd = TXD_PD_SUSPEND;
            CP0_POWER_DOWN_DEEP: m.pd = TXD_PD_DEEP;
            default: m.cls = TXD_CLS_PHI;
          endcase
        end
        else
        begin
          unique case (src1_sel)
            5'h00, 5'h04: m.cls = TXD_CLS_VALID;
            5'h01, 5'h05: m.cls = TXD_CLS_DWORD;
            5'h08: m.cls = (src2_sel[4:2] == 3'h0) ? TXD_CLS_VALID : TXD_CLS_GAMMA;
            default: m.cls = TXD_CLS_GAMMA;
          endcase
        end
      end
      6'h11, 6'h12, 6'h19, 6'h1a, 6'h1d, 6'h1e, 6'h21, 6'h22, 6'h25, 6'h26:
        ;
      default:
        ;
    endcase
    unique case ({row, col})
      6'h13, 6'h1c, 6'h1e, 6'h1f, 6'h30, 6'h33, 6'h34, 6'h38, 6'h3b, 6'h3c:
        m.cls = TXD_CLS_RESERVED;
      6'h31, 6'h32, 6'h35, 6'h36, 6'h39, 6'h3a, 6'h3d, 6'h3e, 6'h11, 6'h12:
        m.cls = TXD_CLS_COPROC;
      6'h18, 6'h19, 6'h1a, 6'h1b, 6'h27, 6'h2c, 6'h2d, 6'h37, 6'h3f:
        m.cls = TXD_CLS_DWORD;
      OP_JUMP_LINK_EXCHANGE: m.cls = TXD_CLS_EXCHANGE;
      default: ;
    endcase
  end
endmodule : txd_opmap

// file: txd_core.sv
// Trap/xor execute slice with opcode classification and exception reporting
`timescale 1ns/10ps
module txd_core
  import txd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [XLEN-1:0] first_source_reg,
  input wire logic [XLEN-1:0] second_source_reg,
  input wire logic mode_64,
  input wire logic compressed_en,
  output logic done_valid,
  output logic wb_en,
  output logic [4:0] wb_addr,
  output logic [XLEN-1:0] wb_data,
  output logic exc_trap,
  output logic exc_reserved,
  output logic exc_coproc,
  output logic [1:0] power_down_req
);
  txd_map_if mbus ();
  txd_opmap u_map (.m(mbus.map));

  logic [5:0] op;
  logic [5:0] fn;
  logic [4:0] src2_f;
  logic [XLEN-1:0] imm_sx;
  logic [XLEN-1:0] imm_zx;
  logic is_fgrp;
  logic is_bgrp;
  logic next_trap;
  logic next_resv;
  logic next_wb;
  logic [4:0] next_wb_addr;
  logic [XLEN-1:0] next_wb_data;
  // Reference results for the checks, kept apart from the datapath
  logic chk_neq_reg;
  logic chk_lt_imm;
  logic chk_neq_imm;
  logic [XLEN-1:0] chk_xor_reg;
  logic [XLEN-1:0] chk_xor_imm;

  assign mbus.instr = issue_instr;
  assign op = issue_instr[OP_HI:OP_LO];
  assign fn = issue_instr[FN_HI:FN_LO];
  assign src2_f = issue_instr[SRC2_HI:SRC2_LO];
  assign imm_sx = {{(XLEN-IMM_W){issue_instr[IMM_W-1]}}, issue_instr[IMM_W-1:0]};
  assign imm_zx = {{(XLEN-IMM_W){1'b0}}, issue_instr[IMM_W-1:0]};
  assign is_fgrp = (op == OP_FUNCTION_GROUP);
  assign is_bgrp = (op == OP_BRANCH_TRAP_IMM);
  assign chk_neq_reg = first_source_reg != second_source_reg;
  assign chk_lt_imm = first_source_reg < imm_sx;
  assign chk_neq_imm = first_source_reg != imm_sx;
  assign chk_xor_reg = first_source_reg ^ second_source_reg;
  assign chk_xor_imm = first_source_reg ^ imm_zx;

  // Code field bits 15:6 enter the block below only as part of imm_sx, in the immediate trap terms
  always_comb
  begin
    next_trap = 1'b0;
    if (is_fgrp && fn == FN_TRAP_LT_U)
      next_trap = first_source_reg < second_source_reg;
    else if (is_fgrp && fn == FN_TRAP_NEQ)
      next_trap = first_source_reg != second_source_reg;
    else if (is_bgrp && src2_f == SEL_TRAP_LT_IMM_U)
      next_trap = first_source_reg < imm_sx;
    else if (is_bgrp && src2_f == SEL_TRAP_NEQ_IMM)
      next_trap = first_source_reg != imm_sx;
  end

  always_comb
  begin
    unique case (mbus.cls)
      TXD_CLS_RESERVED, TXD_CLS_GAMMA, TXD_CLS_XI: next_resv = 1'b1;
      TXD_CLS_DWORD: next_resv = !mode_64;
      TXD_CLS_EXCHANGE: next_resv = !compressed_en;
      default: next_resv = 1'b0;
    endcase
  end

  always_comb
  begin
    next_wb = 1'b0;
    next_wb_addr = issue_instr[RD_HI:RD_LO];
    next_wb_data = first_source_reg ^ second_source_reg;
    if (is_fgrp && fn == FN_XOR)
      next_wb = 1'b1;
    else if (op == OP_XOR_IMM)
    begin
      next_wb = 1'b1;
      next_wb_addr = src2_f;
      next_wb_data = first_source_reg ^ imm_zx;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      done_valid <= 1'b0;
      exc_trap <= 1'b0;
      exc_reserved <= 1'b0;
      exc_coproc <= 1'b0;
    end
    else
    begin
      done_valid <= issue_valid;
      exc_trap <= issue_valid && next_trap && mbus.cls == TXD_CLS_VALID;
      exc_reserved <= issue_valid && next_resv;
      exc_coproc <= issue_valid && mbus.cls == TXD_CLS_COPROC;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wb_en <= 1'b0;
      wb_addr <= 5'h00;
      wb_data <= '0;
    end
    else
    begin
      wb_en <= issue_valid && next_wb;
      wb_addr <= next_wb_addr;
      wb_data <= next_wb_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      power_down_req <= 2'h0;
    else if (issue_valid)
      power_down_req <= mbus.pd[1:0];
    else
      power_down_req <= 2'h0;
  end

  property p_trap_ltu;
    @(posedge core_clk) disable iff (rst)
    issue_valid && is_fgrp && fn == FN_TRAP_LT_U && first_source_reg < second_source_reg
      |=> exc_trap && !wb_en;
  endproperty
  a_trap_ltu: assert property (p_trap_ltu) else $error("unsigned reg trap missed");

  property p_trap_neq;
    @(posedge core_clk) disable iff (rst)
    issue_valid && is_fgrp && fn == FN_TRAP_NEQ |=> exc_trap == $past(chk_neq_reg);
  endproperty
  a_trap_neq: assert property (p_trap_neq) else $error("neq reg trap wrong");

  property p_trap_ltiu;
    @(posedge core_clk) disable iff (rst)
    issue_valid && is_bgrp && src2_f == SEL_TRAP_LT_IMM_U |=> exc_trap == $past(chk_lt_imm);
  endproperty
  a_trap_ltiu: assert property (p_trap_ltiu) else $error("unsigned imm trap wrong");

  property p_trap_neqi;
    @(posedge core_clk) disable iff (rst)
    issue_valid && is_bgrp && src2_f == SEL_TRAP_NEQ_IMM |=> exc_trap == $past(chk_neq_imm);
  endproperty
  a_trap_neqi: assert property (p_trap_neqi) else $error("neq imm trap wrong");

  property p_xor_reg;
    @(posedge core_clk) disable iff (rst)
    issue_valid && is_fgrp && fn == FN_XOR
      |=> wb_en && !exc_trap && wb_data == $past(chk_xor_reg);
  endproperty
  a_xor_reg: assert property (p_xor_reg) else $error("reg xor result wrong");

  property p_xor_imm;
    @(posedge core_clk) disable iff (rst)
    issue_valid && op == OP_XOR_IMM
      |=> wb_en && wb_addr == $past(src2_f) && wb_data == $past(chk_xor_imm);
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("imm xor result wrong");

  property p_dword;
    @(posedge core_clk) disable iff (rst)
    issue_valid && mbus.cls == TXD_CLS_DWORD |=> exc_reserved != $past(mode_64);
  endproperty
  a_dword: assert property (p_dword) else $error("doubleword mode check wrong");

  property p_coproc;
    @(posedge core_clk) disable iff (rst)
    issue_valid && ((op[5:4] == 2'h1 && op[3:2] == 2'h0) || op[5:4] == 2'h3) && ^op[1:0]
      |=> exc_coproc && !exc_reserved;
  endproperty
  a_coproc: assert property (p_coproc) else $error("coprocessor unusable missed");

  property p_exchange;
    @(posedge core_clk) disable iff (rst)
    issue_valid && op == OP_JUMP_LINK_EXCHANGE |=> exc_reserved == !$past(compressed_en);
  endproperty
  a_exchange: assert property (p_exchange) else $error("exchange mode check wrong");

  property p_phi;
    @(posedge core_clk) disable iff (rst)
    issue_valid && mbus.cls == TXD_CLS_PHI |=> !exc_reserved;
  endproperty
  a_phi: assert property (p_phi) else $error("phi raised reserved");

  // Deep request lasts one cycle unless another instruction follows
  sequence s_pd_deep_first;
    power_down_req == 2'h3;
  endsequence
  sequence s_pd_deep_after;
    power_down_req == 2'h0 || $past(issue_valid);
  endsequence
  property p_pd;
    @(posedge core_clk) disable iff (rst)
    issue_valid && op == OP_SYSTEM_COPROC && issue_instr[SRC1_HI] && fn == CP0_POWER_DOWN_DEEP
      |=> s_pd_deep_first ##1 s_pd_deep_after;
  endproperty
  a_pd: assert property (p_pd) else $error("deep power-down not decoded");
endmodule : txd_core

// file: test_trap_xor_opcode_decode.sv
// Self-checking testbench for the trap/xor execute slice
`timescale 1ns/10ps
module test_trap_xor_opcode_decode;
  import txd_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic issue_valid = 1'b0;
  logic [31:0] issue_instr = 32'h0;
  logic [63:0] first_source_reg = 64'h0;
  logic [63:0] second_source_reg = 64'h0;
  logic mode_64 = 1'b1;
  logic compressed_en = 1'b1;
  logic done_valid, wb_en, exc_trap, exc_reserved, exc_coproc;
  logic [4:0] wb_addr;
  logic [63:0] wb_data;
  logic [1:0] power_down_req;
  int errors = 0;
  int check_count = 0;
  logic [5:0] pi_ops [10] = '{6'h11, 6'h12, 6'h31, 6'h32, 6'h35, 6'h36, 6'h39, 6'h3a, 6'h3d,
    6'h3e};
  logic [31:0] rsv_ops [8] = '{32'h4c00_0000, 32'h7000_0000, 32'h0000_0001, 32'h0404_0000,
    32'h4040_0000, 32'h4104_0000, 32'h4200_0010, 32'h4110_0000};

  always #50 core_clk = ~core_clk;

  txd_core dut (.core_clk(core_clk), .rst(rst), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .first_source_reg(first_source_reg),
    .second_source_reg(second_source_reg), .mode_64(mode_64), .compressed_en(compressed_en),
    .done_valid(done_valid), .wb_en(wb_en), .wb_addr(wb_addr), .wb_data(wb_data),
    .exc_trap(exc_trap), .exc_reserved(exc_reserved), .exc_coproc(exc_coproc),
    .power_down_req(power_down_req));

  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Flags in order trap, reserved, coproc, write-enable
  task automatic fl(input logic [3:0] e);
    check("flags", {60'h0, e}, {60'h0, exc_trap, exc_reserved, exc_coproc, wb_en});
  endtask : fl

  // Issue one instruction, sample its answer one cycle later
  task automatic exe(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
    @(negedge core_clk);
    issue_valid = 1'b1;
    issue_instr = ins;
    first_source_reg = a;
    second_source_reg = b;
    @(posedge core_clk);
    @(negedge core_clk);
    issue_valid = 1'b0;
    check("done", 64'h1, {63'h0, done_valid});
  endtask : exe

  task automatic t_trap_reg;
    exe({OP_FUNCTION_GROUP, 5'd1, 5'd2, 10'h3ff, FN_TRAP_LT_U}, 64'h1, '1);
    fl(4'b1000);
    exe({OP_FUNCTION_GROUP, 5'd1, 5'd2, 10'h000, FN_TRAP_LT_U}, '1, 64'h1);
    fl(4'b0000);
    exe({OP_FUNCTION_GROUP, 5'd1, 5'd2, 10'h155, FN_TRAP_NEQ}, 64'h1 << 63, 64'h0);
    fl(4'b1000);
    exe({OP_FUNCTION_GROUP, 5'd1, 5'd2, 10'h2aa, FN_TRAP_NEQ}, 64'h5a, 64'h5a);
    fl(4'b0000);
  endtask : t_trap_reg

  task automatic t_trap_imm;
    exe({OP_BRANCH_TRAP_IMM, 5'd3, SEL_TRAP_LT_IMM_U, 16'h8000}, 64'hffff, 64'h0);
    fl(4'b1000);
    exe({OP_BRANCH_TRAP_IMM, 5'd3, SEL_TRAP_LT_IMM_U, 16'h8000}, 64'hffff_ffff_ffff_8000, 0);
    fl(4'b0000);
    exe({OP_BRANCH_TRAP_IMM, 5'd3, SEL_TRAP_NEQ_IMM, 16'hffff}, '1, 64'h0);
    fl(4'b0000);
    exe({OP_BRANCH_TRAP_IMM, 5'd3, SEL_TRAP_NEQ_IMM, 16'hffff}, 64'hffff, 64'h0);
    fl(4'b1000);
  endtask : t_trap_imm

  task automatic t_xor;
    exe({OP_FUNCTION_GROUP, 5'd1, 5'd2, 5'd7, 5'd0, FN_XOR}, 64'hf0f0, '1);
    fl(4'b0001);
    check("wb_addr", 64'd7, {59'h0, wb_addr});
    check("wb_data", 64'hffff_ffff_ffff_0f0f, wb_data);
    exe({OP_XOR_IMM, 5'd4, 5'd9, 16'h8001}, '1, 64'h0);
    fl(4'b0001);
    check("wb_addr", 64'd9, {59'h0, wb_addr});
    check("wb_data", 64'hffff_ffff_ffff_7ffe, wb_data);
  endtask : t_xor

  task automatic t_classes;
    foreach (rsv_ops[i])
    begin
      exe(rsv_ops[i], 64'h0, 64'h0);
      check("reserved", 64'h1, {63'h0, exc_reserved});
    end
    foreach (pi_ops[i])
    begin
      exe({pi_ops[i], 26'h0}, 64'h0, 64'h0);
      check("coproc", 64'h1, {63'h0, exc_coproc});
    end
    for (int m = 0; m < 2; m++)
    begin
      mode_64 = m[0];
      compressed_en = m[0];
      exe({6'h18, 26'h0}, 64'h0, 64'h0);
      check("dword", {63'h0, ~m[0]}, {63'h0, exc_reserved});
      exe({6'h00, 20'h0, 6'h38}, 64'h0, 64'h0);
      check("dword_fn", {63'h0, ~m[0]}, {63'h0, exc_reserved});
      exe({OP_JUMP_LINK_EXCHANGE, 26'h0}, 64'h0, 64'h0);
      check("exchange", {63'h0, ~m[0]}, {63'h0, exc_reserved});
    end
  endtask : t_classes

  task automatic t_power;
    for (int k = 0; k < 5; k++)
    begin
      exe({OP_SYSTEM_COPROC, 1'b1, 19'h0, k < 3 ? CP0_STANDBY + 6'(k) : 6'h03 + 6'(k)}, 0, 0);
      check("pd", k < 3 ? 64'(k + 1) : 64'h0, {62'h0, power_down_req});
      fl(4'b0000);
    end
  endtask : t_power

  // Trapping instruction followed at once by an xor
  task automatic t_back;
    @(negedge core_clk);
    issue_valid = 1'b1;
    issue_instr = {OP_FUNCTION_GROUP, 5'd1, 5'd2, 10'h0, FN_TRAP_NEQ};
    first_source_reg = 64'h3;
    second_source_reg = 64'h5;
    @(posedge core_clk);
    @(negedge core_clk);
    issue_instr = {OP_FUNCTION_GROUP, 5'd1, 5'd2, 5'd3, 5'd0, FN_XOR};
    fl(4'b1000);
    @(posedge core_clk);
    @(negedge core_clk);
    issue_valid = 1'b0;
    fl(4'b0001);
    check("wb_data", 64'h6, wb_data);
  endtask : t_back

  task automatic conclude;
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    t_trap_reg();
    t_trap_imm();
    t_xor();
    t_classes();
    t_power();
    t_back();
    conclude();
  end
endmodule : test_trap_xor_opcode_decode
